// file: verilog/gcr_receiver.sv
// Functional notes
// - reject bus address above 30, flag error
// - address kept over preset and device clear
// - memory clear sets address to zero
// - SH, AH, talker, listener, SRQ, RL, DC, DT
// - drop space, plus, comma, carriage return
// - line feed ends key code string
// - unknown code sets SRQ, status bit0
// - device trigger rearms sweep
// - no data moves while calibrating
// - one command character held in buffer
// - device clear acts as preset, except debug stays on
// - decode universal, address, addressed commands
// - remote needs ATN, REN and listen address
// - default bus address is eleven
// - data used only remote and listening
// - local listener handshakes, discards data
// - settle delay after frequency change
// - debug on by command or toggle
// - echo chars at right, tilde if unprintable
// - commands not echoed
// - mnemonic pauses half second in debug
// - debug error: beep, marker, ten second pause
// - debug off by command, toggle, preset
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
module gcr_receiver
  import gcr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int ECHO_LEN = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic atn_n,
  input wire logic ren_n,
  input wire logic ifc_n,
  input wire logic dav_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  input wire logic [7:0] dio_n,
  output logic [7:0] dio_n_out,
  output logic dio_oe_n,
  output logic dav_oe_n,
  output logic nrfd_oe_n,
  output logic ndac_oe_n,
  output logic srq_oe_n,
  output logic remote,
  output logic listener,
  output logic talker,
  output logic sweep_rearm,
  output logic preset_pulse,
  output logic beep,
  output logic echo_line_on
);
  localparam int EW = $clog2(ECHO_LEN);

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic [13:0] pin_s;
  gcr_sync #(.W(14), .INIT(14'h3fff)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .d({atn_n, ren_n, ifc_n, dav_n, nrfd_n, ndac_n, dio_n}),
    .q(pin_s)
  );
  logic atn, ren, ifc, dav, nrfd_rel, ndac_rel;
  logic [7:0] rx_b;
  assign atn = ~pin_s[13];
  assign ren = ~pin_s[12];
  assign ifc = ~pin_s[11];
  assign dav = ~pin_s[10];
  assign nrfd_rel = pin_s[9];
  assign ndac_rel = pin_s[8];
  assign rx_b = ~pin_s[7:0];

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  gcr_ah_t ah_q;
  gcr_sh_t sh_q;
  logic [4:0] addr_q;
  logic [2:0] cfg_q;
  logic [5:0] settle_cfg_q;
  logic [7:0] tx_q, buf_q, rx_q, first_q;
  logic tx_v_q, buf_v_q, rx_v_q, let_q, bg_q;
  logic lockout_q, spoll_q, srq_q, unrec_q, range_q;
  logic [15:0] tick_q;
  logic [16:0] pause_q, settle_q;
  logic [7:0] echo_rd;

  // ---------------------------------------------------------------
  // register strobes
  // ---------------------------------------------------------------
  logic wr_cmd, cmd_freq, cmd_preset, cmd_memclr, cmd_local, cmd_tog, cmd_err;
  logic wr_addr, addr_bad;
  assign wr_cmd = reg_wr && reg_addr == REG_CMD;
  assign cmd_freq = wr_cmd && reg_wdata[CMD_FREQ];
  assign cmd_preset = wr_cmd && reg_wdata[CMD_PRESET];
  assign cmd_memclr = wr_cmd && reg_wdata[CMD_MEMCLR];
  assign cmd_local = wr_cmd && reg_wdata[CMD_LOCAL];
  assign cmd_tog = wr_cmd && reg_wdata[CMD_DBG_TOG];
  assign cmd_err = wr_cmd && reg_wdata[CMD_ERR];
  assign wr_addr = reg_wr && reg_addr == REG_BUSADDR;
  assign addr_bad = reg_wdata[15:5] != 11'h000 || reg_wdata[4:0] > ADDR_MAX;

  // ---------------------------------------------------------------
  // acceptor handshake
  // ---------------------------------------------------------------
  logic ah_act, ah_rdy, take, take_cmd, take_dat;
  assign ah_act = atn || listener;
  // data stalls on calibration or, when remote, a full char buffer; commands never
  assign ah_rdy = atn || (!cfg_q[CFG_CAL] && (!remote || !buf_v_q));
  assign take = ah_q == A_READY && ah_act && dav && nrfd_oe_n && ah_rdy;
  assign take_cmd = take && atn;
  assign take_dat = take && !atn && listener;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ah_q <= A_IDLE;
      nrfd_oe_n <= 1'b1;
      ndac_oe_n <= 1'b1;
    end else if (ce) begin
      case (ah_q)
        A_IDLE: if (ah_act) begin
          ah_q <= A_READY;
          ndac_oe_n <= 1'b0;
        end
        A_READY: if (!ah_act) begin
          ah_q <= A_IDLE;
          nrfd_oe_n <= 1'b1;
          ndac_oe_n <= 1'b1;
        end else if (take) begin
          ah_q <= A_HOLD;
          nrfd_oe_n <= 1'b0;
          ndac_oe_n <= 1'b1;
        end else begin
          nrfd_oe_n <= ah_rdy;
        end
        A_HOLD: if (!dav) begin
          ah_q <= ah_act ? A_READY : A_IDLE;
          nrfd_oe_n <= ah_act ? 1'b0 : 1'b1;
          ndac_oe_n <= ~ah_act;
        end
        default: ah_q <= A_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic [6:0] cmd;
  logic c_mla, c_mta, c_ota, c_dcl, c_sdc, c_gtl, c_get, dev_clr, preset_all;
  assign cmd = rx_b[6:0];
  assign c_mla = take_cmd && cmd == {GRP_LISTEN, addr_q};
  assign c_mta = take_cmd && cmd == {GRP_TALK, addr_q};
  assign c_ota = take_cmd && cmd[6:5] == GRP_TALK && cmd != BC_UNT && !c_mta;
  assign c_dcl = take_cmd && cmd == BC_DCL;
  assign c_sdc = take_cmd && cmd == BC_SDC && listener;
  assign c_gtl = take_cmd && cmd == BC_GTL && listener;
  assign c_get = take_cmd && cmd == BC_GET && listener;
  assign dev_clr = c_dcl || c_sdc;
  assign preset_all = dev_clr || cmd_preset;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      listener <= 1'b0;
      talker <= 1'b0;
    end else if (ce) begin
      if (ifc) begin
        listener <= 1'b0;
        talker <= 1'b0;
      end else if (c_mla) begin
        listener <= 1'b1;
        talker <= 1'b0;
      end else if (take_cmd && cmd == BC_UNL) begin
        listener <= 1'b0;
      end else if (c_mta) begin
        talker <= 1'b1;
        listener <= 1'b0;
      end else if (c_ota || (take_cmd && cmd == BC_UNT)) begin
        talker <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      remote <= 1'b0;
      lockout_q <= 1'b0;
    end else if (ce) begin
      if (!ren) begin
        remote <= 1'b0;
        lockout_q <= 1'b0;
      end else begin
        if (c_mla) remote <= 1'b1;
        else if (c_gtl || (cmd_local && !lockout_q)) remote <= 1'b0;
        if (take_cmd && cmd == BC_LLO) lockout_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) spoll_q <= 1'b0;
    else if (ce) begin
      if (ifc || (take_cmd && cmd == BC_SPD)) spoll_q <= 1'b0;
      else if (take_cmd && cmd == BC_SPE) spoll_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sweep_rearm <= 1'b0;
      preset_pulse <= 1'b0;
    end else if (ce) begin
      sweep_rearm <= c_get;
      preset_pulse <= preset_all;
    end
  end

  // ---------------------------------------------------------------
  // character buffer and parser
  // ---------------------------------------------------------------
  logic proc, p_ign, p_lf, p_let, p_dig, p_mnem, p_unrec;
  assign proc = buf_v_q && pause_q == 17'h00000 && settle_q == 17'h00000;

  always_comb begin
    p_ign = buf_q == CH_SP || buf_q == CH_PLUS || buf_q == CH_COMMA || buf_q == CH_CR;
    p_lf = buf_q == CH_LF;
    p_let = buf_q >= 8'h41 && buf_q <= 8'h5a;
    p_dig = buf_q >= 8'h30 && buf_q <= 8'h39;
    p_mnem = let_q && (p_let || p_dig);
    p_unrec = !(p_ign || p_lf || p_let || p_dig || buf_q == 8'h2e || buf_q == 8'h2d);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      buf_v_q <= 1'b0;
      buf_q <= 8'h00;
    end else if (ce) begin
      if (take_dat && remote) begin
        buf_v_q <= 1'b1;
        buf_q <= rx_b;
      end else if (proc || preset_all) begin
        buf_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      let_q <= 1'b0;
      bg_q <= 1'b0;
      first_q <= 8'h00;
    end else if (ce) begin
      if (preset_all || (proc && (p_lf || p_unrec))) begin
        let_q <= 1'b0;
        bg_q <= 1'b0;
      end else if (proc && !p_ign) begin
        if (p_mnem) begin
          let_q <= 1'b0;
          bg_q <= first_q == 8'h42 && buf_q == 8'h47;
        end else if (p_let) begin
          let_q <= 1'b1;
          first_q <= buf_q;
          bg_q <= 1'b0;
        end else begin
          bg_q <= 1'b0;
        end
      end
    end
  end

  // accepted characters go on to software one at a time
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_v_q <= 1'b0;
      rx_q <= 8'h00;
    end else if (ce) begin
      if (proc && !p_ign) begin
        rx_v_q <= 1'b1;
        rx_q <= buf_q;
      end else if (reg_rd && reg_addr == REG_RX) begin
        rx_v_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus debug
  // ---------------------------------------------------------------
  logic dbg_act, err_ev, dbg_on_ev, dbg_off_ev, echo_clr;
  assign dbg_act = echo_line_on && remote;
  assign err_ev = (proc && p_unrec) || (wr_addr && addr_bad) || cmd_err;
  assign dbg_on_ev = proc && bg_q && !let_q && buf_q == 8'h31;
  assign dbg_off_ev = proc && bg_q && !let_q && buf_q == 8'h30;
  assign echo_clr = !echo_line_on && (dbg_on_ev || cmd_tog);

  always_ff @(posedge mclk) begin
    if (!rst_b) echo_line_on <= 1'b0;
    else if (ce) begin
      if (cmd_preset || dbg_off_ev) echo_line_on <= 1'b0;
      else if (cmd_tog) echo_line_on <= ~echo_line_on;
      else if (dbg_on_ev) echo_line_on <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) beep <= 1'b0;
    else if (ce) beep <= err_ev && dbg_act && !cfg_q[CFG_BEEP_DIS];
  end

  gcr_echo #(.LEN(ECHO_LEN)) u_echo (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .clr(echo_clr),
    .push_ch(take_dat && dbg_act),
    .push_mark(err_ev && dbg_act),
    .ch((rx_b >= CH_SP && rx_b < 8'h7f) ? rx_b : CH_TILDE),
    .rd_idx(reg_addr[EW-1:0]),
    .rd_ch(echo_rd)
  );

  // ---------------------------------------------------------------
  // pause and settling timers
  // ---------------------------------------------------------------
  // free-running tick: loads add one tick so a wait is never short
  function automatic logic [16:0] settle_tk(input logic [3:0] r, input logic [1:0] v);
    logic [67:0] row;
    row = 68'h0;
    case (r)
      4'd0: row = {17'd15300, 17'd15300, 17'd15300, 17'd13400};
      4'd1: row = {17'd6920, 17'd7960, 17'd5250, 17'd4630};
      4'd2: row = {17'd2250, 17'd2560, 17'd1750, 17'd1570};
      4'd3: row = {17'd917, 17'd1020, 17'd753, 17'd690};
      4'd4: row = {17'd450, 17'd481, 17'd402, 17'd383};
      4'd5: row = {17'd317, 17'd327, 17'd303, 17'd297};
      4'd6: row = {17'd270, 17'd273, 17'd267, 17'd265};
      4'd7: row = {17'd257, 17'd258, 17'd258, 17'd257};
      default: row = {17'd252, 17'd252, 17'd250, 17'd250};
    endcase
    return row[(3 - v) * 17 +: 17];
  endfunction : settle_tk

  logic tick;
  assign tick = tick_q == 16'h0000;

  always_ff @(posedge mclk) begin
    if (!rst_b) tick_q <= 16'h0000;
    else if (ce) tick_q <= tick ? 16'(TICK_CYCLES - 1) : tick_q - 16'h0001;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) pause_q <= 17'h00000;
    else if (ce) begin
      if (err_ev && dbg_act) pause_q <= ERR_PAUSE_TK + 17'h00001;
      else if (proc && p_mnem && dbg_act && pause_q <= MNEM_PAUSE_TK)
        pause_q <= MNEM_PAUSE_TK + 17'h00001;
      else if (tick && pause_q != 17'h00000) pause_q <= pause_q - 17'h00001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) settle_q <= 17'h00000;
    else if (ce) begin
      if (cmd_freq)
        settle_q <= settle_tk(settle_cfg_q[3:0], settle_cfg_q[5:4]) + 17'h00001;
      else if (tick && settle_q != 17'h00000) settle_q <= settle_q - 17'h00001;
    end
  end

  // ---------------------------------------------------------------
  // source handshake and service request
  // ---------------------------------------------------------------
  logic sh_go, sh_done;
  logic [7:0] stb;
  assign stb = {1'b0, srq_q, 5'h00, unrec_q};
  assign sh_go = (talker || cfg_q[CFG_TALK_ONLY]) && !atn && !cfg_q[CFG_CAL]
                 && (spoll_q || tx_v_q);
  assign sh_done = sh_q == S_DAV && ndac_rel && !atn;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sh_q <= S_IDLE;
      dav_oe_n <= 1'b1;
      dio_oe_n <= 1'b1;
      dio_n_out <= 8'hff;
    end else if (ce) begin
      case (sh_q)
        S_IDLE: if (sh_go) begin
          sh_q <= S_WAIT;
          dio_oe_n <= 1'b0;
          dio_n_out <= ~(spoll_q ? stb : tx_q);
        end
        S_WAIT: if (!sh_go) begin
          sh_q <= S_IDLE;
          dio_oe_n <= 1'b1;
          dio_n_out <= 8'hff;
        end else if (nrfd_rel && !ndac_rel) begin
          sh_q <= S_DAV;
          dav_oe_n <= 1'b0;
        end
        S_DAV: if (atn || sh_done) begin
          sh_q <= S_IDLE;
          dav_oe_n <= 1'b1;
          dio_oe_n <= 1'b1;
          dio_n_out <= 8'hff;
        end
        default: sh_q <= S_IDLE;
      endcase
    end
  end

  logic poll_done, srq_d, unrec_d;
  assign poll_done = sh_done && spoll_q;
  always_comb begin
    srq_d = srq_q;
    unrec_d = unrec_q;
    if (poll_done || preset_all) begin
      srq_d = 1'b0;
      unrec_d = 1'b0;
    end
    if (proc && p_unrec) begin
      srq_d = 1'b1;
      unrec_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      srq_q <= 1'b0;
      unrec_q <= 1'b0;
      srq_oe_n <= 1'b1;
    end else if (ce) begin
      srq_q <= srq_d;
      unrec_q <= unrec_d;
      srq_oe_n <= ~srq_d;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) addr_q <= ADDR_RST;
    else if (ce) begin
      // preset and device clear leave the address alone
      if (cmd_memclr) addr_q <= ADDR_CLR;
      else if (wr_addr && !addr_bad) addr_q <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) range_q <= 1'b0;
    else if (ce) begin
      if (wr_addr && addr_bad) range_q <= 1'b1;
      else if (reg_rd && reg_addr == REG_STATUS) range_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_q <= 3'h0;
      settle_cfg_q <= 6'h00;
    end else if (ce && reg_wr) begin
      if (reg_addr == REG_CFG) cfg_q <= reg_wdata[2:0];
      if (reg_addr == REG_SETTLE) settle_cfg_q <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_v_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_TX) begin
        tx_v_q <= 1'b1;
        tx_q <= reg_wdata[7:0];
      end else if ((sh_done && !spoll_q) || preset_all) begin
        tx_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) reg_rdata <= 16'h0000;
    else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr >= REG_ECHO && reg_addr < REG_ECHO + 6'(ECHO_LEN))
          reg_rdata <= {8'h00, echo_rd};
        else
          case (reg_addr)
            REG_CFG: reg_rdata <= {13'h0000, cfg_q};
            REG_BUSADDR: reg_rdata <= {11'h000, addr_q};
            REG_SETTLE: reg_rdata <= {10'h000, settle_cfg_q};
            REG_TX: reg_rdata <= {7'h00, tx_v_q, tx_q};
            REG_STATUS: reg_rdata <= {2'h0, settle_q != 17'h00000,
                                      pause_q != 17'h00000, echo_line_on, lockout_q,
                                      spoll_q, talker, listener, remote, buf_v_q,
                                      tx_v_q, rx_v_q, range_q, srq_q, unrec_q};
            REG_RX: reg_rdata <= {7'h00, rx_v_q, rx_q};
            default: reg_rdata <= 16'h0000;
          endcase
      end
    end
  end
endmodule : gcr_receiver
`default_nettype wire

// file: pkg/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MNEM_PAUSE_MS = 500;
  localparam int ERR_PAUSE_MS = 10_000;
  localparam logic [16:0] MNEM_PAUSE_TK = 17'(MNEM_PAUSE_MS * 1000 / TICK_US);
  localparam logic [16:0] ERR_PAUSE_TK = 17'(ERR_PAUSE_MS * 1000 / TICK_US);
  // ---------------------------------------------------------------
  // bus address
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_RST = 5'h0b;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_CLR = 5'h00;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CFG = 6'h00;
  localparam logic [5:0] REG_CMD = 6'h01;
  localparam logic [5:0] REG_BUSADDR = 6'h02;
  localparam logic [5:0] REG_SETTLE = 6'h03;
  localparam logic [5:0] REG_TX = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h05;
  localparam logic [5:0] REG_RX = 6'h06;
  localparam logic [5:0] REG_ECHO = 6'h20;
  localparam int CFG_TALK_ONLY = 0;
  localparam int CFG_BEEP_DIS = 1;
  localparam int CFG_CAL = 2;
  localparam int CMD_FREQ = 0;
  localparam int CMD_PRESET = 1;
  localparam int CMD_MEMCLR = 2;
  localparam int CMD_LOCAL = 3;
  localparam int CMD_DBG_TOG = 4;
  localparam int CMD_ERR = 5;
  localparam int STB_UNREC = 0;
  localparam int STB_RQS = 6;
  // ---------------------------------------------------------------
  // bus commands (7 bits, parity bit ignored)
  // ---------------------------------------------------------------
  localparam logic [6:0] BC_DCL = 7'h14;
  localparam logic [6:0] BC_LLO = 7'h11;
  localparam logic [6:0] BC_SPE = 7'h18;
  localparam logic [6:0] BC_SPD = 7'h19;
  localparam logic [6:0] BC_UNL = 7'h3f;
  localparam logic [6:0] BC_UNT = 7'h5f;
  localparam logic [6:0] BC_GTL = 7'h01;
  localparam logic [6:0] BC_SDC = 7'h04;
  localparam logic [6:0] BC_GET = 7'h08;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  // ---------------------------------------------------------------
  // characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_BLOCK = 8'hff;
  typedef enum logic [1:0] {A_IDLE, A_READY, A_HOLD} gcr_ah_t;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DAV} gcr_sh_t;
endpackage : gcr_pkg
`default_nettype wire

// file: verilog/gcr_sync.sv
`default_nettype none
module gcr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : gcr_sync
`default_nettype wire

// file: verilog/gcr_echo.sv
`default_nettype none
module gcr_echo
  import gcr_pkg::*;
#(
  parameter int LEN = 16,
  parameter int IW = $clog2(LEN)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clr,
  input wire logic push_ch,
  input wire logic push_mark,
  input wire logic [7:0] ch,
  input wire logic [IW-1:0] rd_idx,
  output logic [7:0] rd_ch
);
  // index LEN-1 is the right end, newest entry
  logic [7:0] line_q [LEN];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < LEN; i++) line_q[i] <= CH_SP;
    end else if (ce) begin
      if (clr) begin
        for (int i = 0; i < LEN; i++) line_q[i] <= CH_SP;
      end else if (push_ch && push_mark) begin
        // both in one cycle: char first, then marker
        for (int i = 0; i < LEN - 2; i++) line_q[i] <= line_q[i+2];
        line_q[LEN-2] <= ch;
        line_q[LEN-1] <= CH_BLOCK;
      end else if (push_ch || push_mark) begin
        for (int i = 0; i < LEN - 1; i++) line_q[i] <= line_q[i+1];
        line_q[LEN-1] <= push_mark ? CH_BLOCK : ch;
      end
    end
  end

  assign rd_ch = line_q[rd_idx];
endmodule : gcr_echo
`default_nettype wire

// file: dv/gcr_receiver_chk.sv
`default_nettype none
module gcr_receiver_chk
  import gcr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int ECHO_LEN = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ren_n,
  input wire logic dav_n,
  input wire logic [7:0] dio_n_out,
  input wire logic dio_oe_n,
  input wire logic dav_oe_n,
  input wire logic nrfd_oe_n,
  input wire logic ndac_oe_n,
  input wire logic remote,
  input wire logic listener,
  input wire logic talker,
  input wire logic sweep_rearm,
  input wire logic preset_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_remote_listen: assert property ($rose(remote) |-> listener)
    else $error("remote entered without listen address");
  chk_ren_local: assert property (ren_n [*4] |=> !remote)
    else $error("remote kept after ren released");
  chk_addr_excl: assert property (!(talker && listener))
    else $error("talker and listener together");
  chk_dav_data: assert property (!dav_oe_n |-> !dio_oe_n)
    else $error("dav asserted without data");
  chk_dio_idle: assert property (dio_oe_n |-> dio_n_out == 8'hff)
    else $error("data not idle when released");
  chk_accept_hold: assert property ($rose(ndac_oe_n) && !dav_n |-> !nrfd_oe_n)
    else $error("byte accepted with nrfd released");
  chk_rearm_pulse: assert property (sweep_rearm |=> !sweep_rearm)
    else $error("rearm longer than one cycle");
  chk_preset_pulse: assert property (preset_pulse |=> !preset_pulse)
    else $error("preset longer than one cycle");
endmodule : gcr_receiver_chk
bind gcr_receiver gcr_receiver_chk #(.TICK_CYCLES(TICK_CYCLES), .ECHO_LEN(ECHO_LEN)) chk (.*);
`default_nettype wire

// file: dv/gcr_ctl_model.sv
`default_nettype none
module gcr_ctl_model (
  input wire logic mclk,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic dav_w,
  input wire logic [7:0] dio_w,
  output logic atn_n = 1'b1,
  output logic dav_c = 1'b1,
  output logic nrfd_c = 1'b1,
  output logic ndac_c = 1'b1,
  output logic [7:0] dio_c = 8'hff
);
  timeunit 1ns;
  timeprecision 1ns;
  // long first wait: device may hold off through a mnemonic pause
  task automatic send(input logic [7:0] b, input logic atn, output logic ok);
    int n;
    atn_n <= !atn;
    dio_c <= ~b;
    @(posedge mclk);
    for (n = 0; n < 30000 && {nrfd_w, ndac_w} !== 2'b10; n++) @(posedge mclk);
    ok = nrfd_w & !ndac_w;
    dav_c <= 1'b0;
    @(posedge mclk);
    for (n = 0; n < 99 && ndac_w !== 1'b1; n++) @(posedge mclk);
    ok = ok & ndac_w;
    dav_c <= 1'b1;
    dio_c <= 8'hff;
    @(posedge mclk);
  endtask : send
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    atn_n <= 1'b1;
    ndac_c <= 1'b0;
    for (n = 0; n < 99 && dav_w !== 1'b0; n++) @(posedge mclk);
    ok = !dav_w;
    b = ~dio_w;
    nrfd_c <= 1'b0;
    ndac_c <= 1'b1;
    for (n = 0; n < 99 && dav_w !== 1'b1; n++) @(posedge mclk);
    ok = ok & dav_w;
    nrfd_c <= 1'b1;
  endtask : recv
endmodule : gcr_ctl_model
`default_nettype wire

// file: dv/gpib_command_receiver_test.sv
`default_nettype none
module gpib_command_receiver_test;
  import gcr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ren_n = 1'b1, rd_q = 1'b0;
  logic ok, atn_n, dav_c, nrfd_c, ndac_c, dio_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n;
  logic srq_oe_n, remote, listener, talker, sweep_rearm, preset_pulse, beep, echo_line_on;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, expq[$];
  logic [7:0] dio_n_out, dio_c, b;
  logic [4:0] ma;
  logic [31:0] lf = 32'ha4c0;
  logic [7:0] ign[5] = '{CH_SP, CH_PLUS, CH_COMMA, CH_CR, CH_LF};
  logic [7:0] bg[6] = '{8'h42, 8'h47, 8'h31, CH_LF, 8'h35, CH_LF};
  int miscompares = 0, n_compared = 0, n_sw = 0, n_pre = 0;
  wire logic ce = 1'b1, ifc_n = 1'b1;
  wire logic dav_n = dav_c & dav_oe_n, nrfd_n = nrfd_c & nrfd_oe_n, ndac_n = ndac_c & ndac_oe_n;
  wire logic [7:0] dio_n = dio_c & (dio_oe_n ? 8'hff : dio_n_out);
  gcr_receiver #(.TICK_CYCLES(4)) uut (.*);
  gcr_ctl_model ctl (.mclk, .nrfd_w(nrfd_n), .ndac_w(ndac_n), .dav_w(dav_n), .dio_w(dio_n),
    .atn_n, .dav_c, .nrfd_c, .ndac_c, .dio_c);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic end_sim;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    expq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic snd(input logic [7:0] c, input logic a);
    ctl.send(c, a, ok);
    cmp({15'h0, ok}, 16'h0001);
  endtask : snd
  always @(posedge mclk) begin
    if (rd_q) cmp(reg_rdata, expq.pop_front());
    rd_q <= reg_rd;
    n_sw <= n_sw + int'(sweep_rearm === 1'b1);
    n_pre <= n_pre + int'(preset_pulse === 1'b1);
  end
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(REG_BUSADDR, 16'h000b);
    rd(6'h3f, 16'h0000);
    wr(REG_BUSADDR, 16'h001f);
    rd(REG_BUSADDR, 16'h000b);
    rd(REG_STATUS, 16'h0004);
    lf = nx(lf);
    ma = 5'(lf % 30) + 5'h01;
    wr(REG_BUSADDR, {11'h0, ma});
    wr(REG_CMD, 16'h0001 << CMD_MEMCLR);
    rd(REG_BUSADDR, 16'h0000);
    wr(REG_BUSADDR, {11'h0, ma});
    wr(REG_CMD, 16'h0001 << CMD_PRESET);
    rd(REG_BUSADDR, {11'h0, ma});
    $display("done: address");
    snd({3'h1, ma}, 1'b1);
    snd(8'h23, 1'b0);
    snd(CH_LF, 1'b0);
    cmp({13'h0, listener, remote, srq_oe_n}, 16'h0005);
    ren_n <= 1'b0;
    repeat (3) @(posedge mclk);
    snd({3'h1, ma}, 1'b1);
    foreach (ign[i]) snd(ign[i], 1'b0);
    cmp({14'h0, remote, srq_oe_n}, 16'h0003);
    snd(8'h23, 1'b0);
    snd(CH_SP, 1'b0);
    repeat (8) @(posedge mclk);
    cmp({15'h0, srq_oe_n}, 16'h0000);
    $display("done: listen");
    snd(BC_SPE, 1'b1);
    snd({3'h2, ma}, 1'b1);
    ctl.recv(b, ok);
    cmp({7'h0, ok, b}, 16'h0141);
    snd(BC_SPD, 1'b1);
    repeat (4) @(posedge mclk);
    cmp({15'h0, srq_oe_n}, 16'h0001);
    snd({3'h1, ma}, 1'b1);
    snd(BC_GET, 1'b1);
    snd(BC_DCL, 1'b1);
    repeat (4) @(posedge mclk);
    cmp({n_sw[7:0], n_pre[7:0]}, 16'h0102);
    $display("done: poll");
    foreach (bg[i]) snd(bg[i], 1'b0);
    rd(6'h2e, 16'h0035);
    rd(6'h2f, {8'h0, CH_TILDE});
    snd(BC_DCL, 1'b1);
    rd(6'h2f, {8'h0, CH_TILDE});
    cmp({15'h0, echo_line_on}, 16'h0001);
    wr(REG_CMD, 16'h0001 << CMD_ERR);
    rd(6'h2f, 16'h00ff);
    wr(REG_CMD, 16'h0001 << CMD_PRESET);
    repeat (2) @(posedge mclk);
    cmp({15'h0, echo_line_on}, 16'h0000);
    $display("done: debug");
    end_sim();
  end
endmodule : gpib_command_receiver_test
`default_nettype wire
